// file: cfm_pkg.sv
package cfm_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_FILTERS    = 32;
    localparam int NUM_ROUTE_REGS = 8;
    localparam int NUM_QUEUES     = 33;   // Event queue, tx queue, FIFO 1..31
    localparam int RAM_WORDS      = 512;  // 2 KB of 32-bit words
    localparam int RAM_AW         = 9;
    localparam int CHECK_W        = 7;
    localparam int HEADER_WORDS   = 2;

    // ------------------------------------------------------------
    // Register word indices
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_ROUTE_BASE = 8'h00;
    localparam logic [7:0] ADDR_VALUE_BASE = 8'h20;
    localparam logic [7:0] ADDR_MASK_BASE  = 8'h40;
    localparam logic [7:0] ADDR_CTRL       = 8'h60;
    localparam logic [7:0] ADDR_PROTECT    = 8'h61;
    localparam logic [7:0] ADDR_QUEUE_BASE = 8'h80;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LANE_W        = 8;
    localparam int POS_LANE_EN   = 7;
    localparam int PTR_W         = 5;
    localparam int POS_TYPE      = 30;   // Type select / type match enable
    localparam int ID_W          = 30;   // Twelfth bit, extended and base id
    localparam int POS_CFG_MODE  = 0;
    localparam int POS_EVT_EN    = 1;
    localparam int POS_TXQ_EN    = 2;
    localparam int POS_PROT_EN   = 0;
    localparam int POS_PARITY    = 8;
    localparam int POS_SINGLE    = 16;
    localparam int POS_DOUBLE    = 17;
    localparam int POS_Q_COUNT   = 0;
    localparam int POS_Q_PLSIZE  = 8;
    localparam int POS_Q_UADDR   = 16;
    localparam int Q_COUNT_W     = 5;
    localparam int Q_PLSIZE_W    = 3;
    localparam int UADDR_W       = 11;
    localparam int POS_RX_HITIDX = 11;   // Matched-filter field in a stored rx object

    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    localparam logic [4:0]  QUEUE_EVENT = 5'h00;
    localparam logic [4:0]  QUEUE_TX    = 5'h01;

endpackage

// file: cfm_filter_ram.sv
`timescale 1ns/1ps
module cfm_filter_ram
    import cfm_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic                 ce,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    output logic      [31:0]          reg_rdata,
    input  wire logic                 rx_valid,
    input  wire logic                 rx_is_ext,
    input  wire logic                 rx_twelfth,
    input  wire logic [17:0]          rx_ext_id,
    input  wire logic [10:0]          rx_base_id,
    output logic                      match_valid,
    output logic                      match_hit,
    output logic      [PTR_W-1:0]     match_fifo,
    output logic      [PTR_W-1:0]     match_filter_index,
    input  wire logic                 q_advance,
    input  wire logic [4:0]           q_select,
    input  wire logic                 ram_wr,
    input  wire logic                 ram_rd,
    input  wire logic [RAM_AW-1:0]    ram_addr,
    input  wire logic [31:0]          ram_wdata,
    output logic      [31:0]          ram_rdata,
    output logic                      ram_rvalid,
    output logic                      ram_single_err,
    output logic                      ram_double_err
);

    // ------------------------------------------------------------
    // Check-bit code and payload size functions
    // ------------------------------------------------------------
    // Hamming over positions 1..38 with data at non-power-of-two
    // positions, plus one overall parity bit.
    function automatic logic [CHECK_W-1:0] ecc_encode(input logic [31:0] d);
        logic [CHECK_W-1:0] p;
        int                 j;
        p = '0;
        j = 0;
        for (int pos = 1; pos < 39; pos++) begin
            if ((pos & (pos - 1)) != 0) begin
                for (int i = 0; i < 6; i++) begin
                    if (pos[i]) begin
                        p[i] = p[i] ^ d[j];
                    end
                end
                j = j + 1;
            end
        end
        p[6] = (^d) ^ (^p[5:0]);
        return p;
    endfunction

    // Corrects the data bit at the syndrome position, if it is a data bit
    function automatic logic [31:0] ecc_fix(input logic [31:0] d, input logic [5:0] s);
        logic [31:0] r;
        int          j;
        r = d;
        j = 0;
        for (int pos = 1; pos < 39; pos++) begin
            if ((pos & (pos - 1)) != 0) begin
                if (pos[5:0] == s) begin
                    r[j] = ~r[j];
                end
                j = j + 1;
            end
        end
        return r;
    endfunction

    // Five bits wide so the largest payload of sixteen words does not wrap
    function automatic logic [4:0] payload_words(input logic [Q_PLSIZE_W-1:0] code);
        case (code)
            3'h0:    payload_words = 5'h02;
            3'h1:    payload_words = 5'h03;
            3'h2:    payload_words = 5'h04;
            3'h3:    payload_words = 5'h05;
            3'h4:    payload_words = 5'h06;
            3'h5:    payload_words = 5'h08;
            3'h6:    payload_words = 5'h0c;
            default: payload_words = 5'h10;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [31:0]            route      [NUM_ROUTE_REGS];
    logic [31:0]            match_val  [NUM_FILTERS];
    logic [31:0]            match_mask [NUM_FILTERS];
    logic [Q_COUNT_W-1:0]   q_count    [NUM_QUEUES];
    logic [Q_PLSIZE_W-1:0]  q_plsize   [NUM_QUEUES];
    logic [Q_COUNT_W-1:0]   q_head     [NUM_QUEUES];
    logic [31+CHECK_W:0]    ram        [RAM_WORDS];
    logic                   config_mode;
    logic                   event_store_enable;
    logic                   tx_queue_enable;
    logic                   ram_protect_enable;
    logic [CHECK_W-1:0]     manual_parity;
    logic                   last_single;
    logic                   last_double;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    wire       sel_route = reg_addr < ADDR_ROUTE_BASE + 8'(NUM_ROUTE_REGS);
    wire       sel_value = reg_addr >= ADDR_VALUE_BASE && reg_addr < ADDR_MASK_BASE;
    wire       sel_mask  = reg_addr >= ADDR_MASK_BASE && reg_addr < ADDR_CTRL;
    wire       sel_queue = reg_addr >= ADDR_QUEUE_BASE
                           && reg_addr < ADDR_QUEUE_BASE + 8'(NUM_QUEUES);
    wire [2:0] route_idx = reg_addr[2:0];
    wire [4:0] filt_idx  = reg_addr[4:0];
    wire [5:0] q_idx     = reg_addr[5:0];

    // ------------------------------------------------------------
    // Filter matching
    // ------------------------------------------------------------
    logic [NUM_FILTERS-1:0] filt_en;
    logic [NUM_FILTERS-1:0] filt_hit;
    logic [PTR_W-1:0]       filt_ptr [NUM_FILTERS];
    wire  [ID_W-1:0]        rx_id = {rx_twelfth, rx_ext_id, rx_base_id};

    // Each filter compares only the bits its mask selects
    always_comb begin
        for (int f = 0; f < NUM_FILTERS; f++) begin
            filt_en[f]  = route[f/4][LANE_W*(f%4)+POS_LANE_EN];
            filt_ptr[f] = route[f/4][LANE_W*(f%4) +: PTR_W];
            filt_hit[f] = filt_en[f]
                && (((match_val[f][ID_W-1:0] ^ rx_id)
                     & match_mask[f][ID_W-1:0]) == '0)
                && (!match_mask[f][POS_TYPE]
                    || match_val[f][POS_TYPE] == rx_is_ext);
        end
    end

    // Scan from the top so the lowest index wins
    logic             any_hit;
    logic [PTR_W-1:0] win_idx;
    always_comb begin
        any_hit = 1'b0;
        win_idx = '0;
        for (int f = NUM_FILTERS - 1; f >= 0; f--) begin
            if (filt_hit[f]) begin
                any_hit = 1'b1;
                win_idx = PTR_W'(f);
            end
        end
    end

    // ------------------------------------------------------------
    // Memory allocation
    // ------------------------------------------------------------
    // Running sum of enabled queue sizes; a fully loaded map can run
    // past 2 KB and then wraps, so software must size queues to fit.
    logic [15:0]        q_base  [NUM_QUEUES];
    logic [4:0]         q_objw  [NUM_QUEUES];
    logic [UADDR_W-1:0] q_uaddr [NUM_QUEUES];
    logic [15:0]        acc;
    logic               q_on;
    always_comb begin
        acc = '0;
        for (int q = 0; q < NUM_QUEUES; q++) begin
            q_objw[q] = 5'(HEADER_WORDS) + 5'(payload_words(q_plsize[q]));
            q_on      = (q == 0) ? event_store_enable
                      : (q == 1) ? tx_queue_enable : 1'b1;
            q_base[q] = acc;
            if (q_on) begin
                acc = 16'(acc + q_count[q] * q_objw[q]);
            end
            q_uaddr[q] = UADDR_W'((q_base[q] + q_head[q] * q_objw[q]) << 2);
        end
    end

    // ------------------------------------------------------------
    // Memory read path
    // ------------------------------------------------------------
    wire [31+CHECK_W:0] rd_word  = ram[ram_addr];
    wire [31:0]         rd_data  = rd_word[31:0];
    wire [CHECK_W-1:0]  rd_check = rd_word[31+CHECK_W:32];
    wire [CHECK_W-1:0]  re_check = ecc_encode(rd_data);
    wire [5:0]          syndrome = rd_check[5:0] ^ re_check[5:0];
    wire                par_bad  = (^rd_check) ^ (^re_check);
    wire                err_one  = ram_protect_enable && par_bad;
    wire                err_two  = ram_protect_enable && !par_bad && syndrome != '0;
    wire [31:0]         rd_fixed = err_one ? ecc_fix(rd_data, syndrome) : rd_data;
    wire [CHECK_W-1:0]  wr_check = ram_protect_enable ? ecc_encode(ram_wdata)
                                                      : manual_parity;

    // ------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------
    // Route lanes are rebuilt from fields so gap bits read zero
    logic [31:0] route_read;
    always_comb begin
        route_read = '0;
        for (int l = 0; l < 4; l++) begin
            route_read[LANE_W*l+POS_LANE_EN]  = route[route_idx][LANE_W*l+POS_LANE_EN];
            route_read[LANE_W*l +: PTR_W]      = route[route_idx][LANE_W*l +: PTR_W];
        end
    end

    wire [31:0] ctrl_read  = 32'({tx_queue_enable, event_store_enable, config_mode});
    wire [31:0] prot_read  = 32'({last_double, last_single}) << POS_SINGLE
                           | 32'(manual_parity) << POS_PARITY
                           | 32'(ram_protect_enable);
    wire [31:0] queue_read = 32'(q_uaddr[q_idx]) << POS_Q_UADDR
                           | 32'(q_plsize[q_idx]) << POS_Q_PLSIZE
                           | 32'(q_count[q_idx]);
    wire [31:0] next_rdata = sel_route ? route_read
                           : sel_value ? match_val[filt_idx]
                           : sel_mask  ? match_mask[filt_idx]
                           : reg_addr == ADDR_CTRL    ? ctrl_read
                           : reg_addr == ADDR_PROTECT ? prot_read
                           : sel_queue ? queue_read : RESET_VALUE;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Enable bits always writable; pointers only under a clear enable
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int r = 0; r < NUM_ROUTE_REGS; r++) begin
                route[r] <= RESET_VALUE;
            end
        end else if (ce && reg_wr && sel_route) begin
            for (int l = 0; l < 4; l++) begin
                route[route_idx][LANE_W*l+POS_LANE_EN] <= reg_wdata[LANE_W*l+POS_LANE_EN];
                if (!route[route_idx][LANE_W*l+POS_LANE_EN]) begin
                    route[route_idx][LANE_W*l +: PTR_W] <= reg_wdata[LANE_W*l +: PTR_W];
                end
            end
        end
    end

    // Match values locked while their filter is live
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int f = 0; f < NUM_FILTERS; f++) begin
                match_val[f]  <= RESET_VALUE;
                match_mask[f] <= RESET_VALUE;
            end
        end else if (ce && reg_wr) begin
            if (sel_value && !filt_en[filt_idx]) begin
                match_val[filt_idx] <= {1'b0, reg_wdata[POS_TYPE:0]};
            end
            if (sel_mask) begin
                match_mask[filt_idx] <= {1'b0, reg_wdata[POS_TYPE:0]};
            end
        end
    end

    // Control and protection settings
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            config_mode        <= 1'b0;
            event_store_enable <= 1'b0;
            tx_queue_enable    <= 1'b0;
            ram_protect_enable <= 1'b0;
            manual_parity      <= '0;
        end else if (ce && reg_wr) begin
            if (reg_addr == ADDR_CTRL) begin
                config_mode <= reg_wdata[POS_CFG_MODE];
                if (config_mode) begin
                    event_store_enable <= reg_wdata[POS_EVT_EN];
                    tx_queue_enable    <= reg_wdata[POS_TXQ_EN];
                end
            end
            if (reg_addr == ADDR_PROTECT) begin
                ram_protect_enable <= reg_wdata[POS_PROT_EN];
                manual_parity      <= reg_wdata[POS_PARITY +: CHECK_W];
            end
        end
    end

    // Queue sizing and the head index behind each user address;
    // heads rewind in configuration mode so a new layout starts clean
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int q = 0; q < NUM_QUEUES; q++) begin
                q_count[q]  <= '0;
                q_plsize[q] <= '0;
                q_head[q]   <= '0;
            end
        end else if (ce) begin
            if (reg_wr && sel_queue && config_mode) begin
                q_count[q_idx]  <= reg_wdata[POS_Q_COUNT +: Q_COUNT_W];
                q_plsize[q_idx] <= reg_wdata[POS_Q_PLSIZE +: Q_PLSIZE_W];
            end
            for (int q = 0; q < NUM_QUEUES; q++) begin
                if (config_mode) begin
                    q_head[q] <= '0;
                end else if (q_advance && 6'(q_select) + 6'd1 == 6'(q)
                             || q_advance && q_select == QUEUE_EVENT && q == 0) begin
                    q_head[q] <= (q_head[q] + 5'd1 >= q_count[q]) ? '0
                                                                 : q_head[q] + 5'd1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Message memory and outputs
    // ------------------------------------------------------------
    // Data plus check bits, no reset on the array itself
    always_ff @(posedge sys_clk) begin
        if (ce && ram_wr) begin
            ram[ram_addr] <= {wr_check, ram_wdata};
        end
    end

    // Read data returns one cycle after the request
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ram_rdata      <= RESET_VALUE;
            ram_rvalid     <= 1'b0;
            ram_single_err <= 1'b0;
            ram_double_err <= 1'b0;
            last_single    <= 1'b0;
            last_double    <= 1'b0;
        end else if (ce) begin
            ram_rvalid     <= ram_rd;
            ram_single_err <= ram_rd && err_one;
            ram_double_err <= ram_rd && err_two;
            if (ram_rd) begin
                ram_rdata   <= rd_fixed;
                last_single <= err_one;
                last_double <= err_two;
            end
        end
    end

    // Registered match result and register read data
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata          <= RESET_VALUE;
            match_valid        <= 1'b0;
            match_hit          <= 1'b0;
            match_fifo         <= '0;
            match_filter_index <= '0;
        end else if (ce) begin
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
            match_valid <= rx_valid;
            if (rx_valid) begin
                match_hit          <= any_hit;
                match_fifo         <= any_hit ? filt_ptr[win_idx] : '0;
                match_filter_index <= win_idx;
            end
        end
    end

endmodule

// file: cfm_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the filter and RAM block
// ----------------------------------------
module cfm_monitor
    import cfm_pkg::*;
(
    input wire logic             sys_clk,
    input wire logic             reset,
    input wire logic             ce,
    input wire logic             reg_rd,
    input wire logic [7:0]       reg_addr,
    input wire logic [31:0]      reg_rdata,
    input wire logic             rx_valid,
    input wire logic             match_valid,
    input wire logic             match_hit,
    input wire logic [PTR_W-1:0] match_fifo,
    input wire logic [PTR_W-1:0] match_filter_index,
    input wire logic             ram_rd,
    input wire logic             ram_rvalid,
    input wire logic             ram_single_err,
    input wire logic             ram_double_err
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Each answer is tied to its request one cycle earlier
    property p_match_next; rx_valid && ce |=> match_valid; endproperty
    a_match_next: assert property (p_match_next) else $error("no match answer");
    // A frozen clock enable holds the answer, so only a live edge needs a cause
    property p_match_cause; match_valid && $past(ce) |-> $past(rx_valid); endproperty
    a_match_cause: assert property (p_match_cause) else $error("stray match");
    property p_miss_zero;
        match_valid && !match_hit |-> match_fifo == 5'h00 && match_filter_index == 5'h00;
    endproperty
    a_miss_zero: assert property (p_miss_zero) else $error("miss not zero");
    // Unused lane bits never leak out, whatever was written
    property p_pad_zero;
        reg_rd && ce && reg_addr < 8'h08 |=> (reg_rdata & 32'h6060_6060) == 32'h0000_0000;
    endproperty
    a_pad_zero: assert property (p_pad_zero) else $error("lane pad bits set");
    property p_ram_next; ram_rd && ce |=> ram_rvalid; endproperty
    a_ram_next: assert property (p_ram_next) else $error("no ram answer");
    property p_ram_cause; ram_rvalid && $past(ce) |-> $past(ram_rd); endproperty
    a_ram_cause: assert property (p_ram_cause) else $error("stray ram answer");
    property p_err_valid; ram_single_err || ram_double_err |-> ram_rvalid; endproperty
    a_err_valid: assert property (p_err_valid) else $error("flag without data");
    property p_err_excl; ram_rvalid |-> !(ram_single_err && ram_double_err); endproperty
    a_err_excl: assert property (p_err_excl) else $error("both flags set");
    // Main scenarios seen
    c_hit: cover property (match_valid && match_hit);
    c_single: cover property (ram_single_err);
    c_double: cover property (ram_double_err);
endmodule

bind cfm_filter_ram cfm_monitor cfm_monitor_inst (.*);

// file: cfm_host_model.sv
`timescale 1ns/1ps
// Host side of the register bus; one strobe per access
module cfm_host_model
    import cfm_pkg::*;
(
    input  wire logic        sys_clk,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [7:0]       reg_addr,
    output logic [31:0]      reg_wdata
);
    // Idle bus at time zero
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0000_0000;
    end
    // Callers never enable a lane with a zero pointer
    task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= w;
        reg_rd    <= ~w;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        reg_wdata <= ~d; // Released bus must not echo the word
    endtask
endmodule

// file: tb.sv
`timescale 1ns/1ps
module tb
    import cfm_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic        ce = 1'b1;
    logic        reg_wr, reg_rd, rx_valid, rx_is_ext, rx_twelfth, q_advance;
    logic        ram_wr, ram_rd, ram_rvalid, ram_single_err, ram_double_err, rd_d;
    logic        match_valid, match_hit;
    logic [4:0]  match_fifo, match_filter_index, q_select;
    logic [7:0]  reg_addr, r;
    logic [8:0]  ram_addr;
    logic [10:0] rx_base_id;
    logic [17:0] rx_ext_id;
    logic [31:0] reg_wdata, reg_rdata, ram_wdata, ram_rdata, d;
    logic [33:0] q_reg[$], q_mat[$], q_ram[$];
    int          n_errors = 0;
    int          checks = 0;

    always #2 sys_clk = ~sys_clk;

    cfm_filter_ram cfm_filter_ram_inst (.*);
    cfm_host_model cfm_host_model_inst (.*);

    // ----------------------------------------
    // Drivers; each read notes what it expects
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        cfm_host_model_inst.access(1'b1, a, v);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q_reg.push_back({2'b00, e});
        cfm_host_model_inst.access(1'b0, a, 32'h0000_0000);
    endtask
    task automatic rx(input logic x, input logic [10:0] b, input logic [10:0] e);
        q_mat.push_back({23'h0, e});
        @(posedge sys_clk);
        rx_valid   <= 1'b1;
        rx_is_ext  <= x;
        rx_base_id <= b;
        rx_ext_id  <= 18'($urandom());
        rx_twelfth <= 1'($urandom());
        @(posedge sys_clk);
        rx_valid <= 1'b0;
    endtask
    task automatic ram(input logic w, input logic [8:0] a, input logic [31:0] v,
                       input logic [33:0] e);
        if (!w) q_ram.push_back(e);
        @(posedge sys_clk);
        ram_wr    <= w;
        ram_rd    <= ~w;
        ram_addr  <= a;
        ram_wdata <= v;
        @(posedge sys_clk);
        ram_wr    <= 1'b0;
        ram_rd    <= 1'b0;
        ram_wdata <= ~v;
    endtask
    task automatic cmp(input logic [33:0] e, input logic [33:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic cmp_reg(input logic [33:0] e, input logic [31:0] g);
        cmp(e, {2'b00, g});
    endtask
    task automatic cmp_match(input logic [33:0] e, input logic [10:0] g);
        cmp(e, {23'h0, g});
    endtask
    task automatic cmp_ram(input logic [33:0] e, input logic [33:0] g);
        cmp(e, g);
    endtask
    task automatic finish_test();
        if (q_reg.size() + q_mat.size() + q_ram.size() != 0) n_errors++;
        if (n_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Watcher: read data has no strobe, so track the read one cycle late
    always @(posedge sys_clk) rd_d <= reg_rd;
    always @(negedge sys_clk) begin
        if (rd_d === 1'b1) cmp_reg(q_reg.pop_front(), reg_rdata);
        if (match_valid === 1'b1)
            cmp_match(q_mat.pop_front(), {match_hit, match_fifo, match_filter_index});
        if (ram_rvalid === 1'b1)
            cmp_ram(q_ram.pop_front(), {ram_single_err, ram_double_err, ram_rdata});
    end

    // Hang guard, far beyond the roughly 140 cycles the run needs
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        finish_test();
    end

    initial begin
        void'($urandom(82936));
        {rx_valid, rx_is_ext, rx_twelfth, q_advance, ram_wr, ram_rd} = 6'h00;
        {q_select, ram_addr, rx_base_id, rx_ext_id, ram_wdata} = '0;
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        rd(8'h00, 32'h0000_0000);
        rd(8'h3F, 32'h0000_0000);
        rd(8'h5F, 32'h0000_0000);
        wr(8'h70, 32'hFFFF_FFFF);
        rd(8'h70, 32'h0000_0000);
        wr(8'h20, 32'h8000_0123);
        rd(8'h20, 32'h0000_0123);
        wr(8'h21, 32'h0000_0123);
        wr(8'h40, 32'h0000_07FF);
        wr(8'h41, 32'h0000_0700);
        rd(8'h40, 32'h0000_07FF);
        wr(8'h22, 32'h4000_0000);
        wr(8'h42, 32'h4000_0000);
        wr(8'h00, 32'h0000_87E5);
        rd(8'h00, 32'h0000_8785);
        wr(8'h00, 32'h0000_8383);
        rd(8'h00, 32'h0000_8785);
        wr(8'h20, 32'h0000_0456);
        rd(8'h20, 32'h0000_0123);
        rx(1'b0, 11'h123, 11'h4A0);
        rx(1'b0, 11'h1AB, 11'h4E1);
        rx(1'b1, 11'h423, 11'h000);
        repeat (8) begin
            r = 8'($urandom());
            rx(r[0], {3'b001, r}, (r == 8'h23) ? 11'h4A0 : 11'h4E1);
        end
        wr(8'h00, 32'h0089_8705);
        rx(1'b1, 11'h423, 11'h522);
        rx(1'b0, 11'h423, 11'h000);
        rx(1'b0, 11'h123, 11'h4E1);
        // Layout: event 2 objects of 4 words, tx queue 1 of 18, FIFO1 3 of 4
        wr(8'h60, 32'h0000_0001);
        wr(8'h60, 32'h0000_0007);
        wr(8'h80, 32'h0000_0002);
        wr(8'h81, 32'h0000_0701);
        wr(8'h82, 32'h0000_0003);
        rd(8'h82, 32'h0068_0003);
        wr(8'h60, 32'h0000_0005);
        rd(8'h82, 32'h0048_0003);
        wr(8'h60, 32'h0000_0006);
        wr(8'h82, 32'h0000_0005);
        @(posedge sys_clk);
        q_advance <= 1'b1;
        q_select  <= 5'd1;
        @(posedge sys_clk);
        q_advance <= 1'b0;
        q_select  <= 5'd9;
        rd(8'h82, 32'h0078_0003);
        // Zero word has zero check bits, so flips of stored data are known
        d = $urandom();
        wr(8'h61, 32'h0000_0001);
        ram(1'b1, 9'h1F0, d, 34'h0);
        ram(1'b0, 9'h1F0, d, {2'b00, d});
        ram(1'b1, 9'h011, 32'h0000_0000, 34'h0);
        wr(8'h61, 32'h0000_0000);
        ram(1'b1, 9'h011, 32'h0000_0001, 34'h0);
        ram(1'b0, 9'h011, 32'h0, 34'h0_0000_0001);
        wr(8'h61, 32'h0000_0001);
        ram(1'b0, 9'h011, 32'h0, 34'h2_0000_0000);
        wr(8'h61, 32'h0000_0000);
        ram(1'b1, 9'h011, 32'h0000_0003, 34'h0);
        wr(8'h61, 32'h0000_0001);
        ram(1'b0, 9'h011, 32'h0, 34'h1_0000_0003);
        rd(8'h61, 32'h0002_0001);
        // Frozen clock enable must swallow a write
        @(posedge sys_clk);
        ce <= 1'b0;
        wr(8'h00, 32'h0000_0000);
        ce <= 1'b1;
        rd(8'h00, 32'h0089_8705);
        repeat (4) @(posedge sys_clk);
        finish_test();
    end
endmodule
